// ### logic/pmcm_pkg.sv
/*
 Shared constants and types of the power-mode and clock manager.
 Assumes one 100 MHz system clock and a synchronous active-low reset.
*/
// How it works
// - Idle gates processor and memory clocks only
// - Standby powers always-on; wakes on ext/rtc/sensor
// - Standby wake keeps retention and resumes processor
// - Pins hold latched state throughout standby
// - Shutdown removes all power, latches pin values
// - Shutdown pin level change wakes as reset
// - Reset cause register tells wake, pin, power-on
// - Shutdown keeps only pin latch, flash contents
// - Main clock on in active/idle, off otherwise
// - Medium clock always from medium RC oscillator
// - Slow clock source selectable, runs through standby
// - Radio allowed only with fast crystal main clock
// - Slow clock drivable out for crystal or RC
// - Radio timer resynced to RTC on switch
// - Watchdog counts own tick, cannot be stopped
// - Watchdog freezes in standby/debug, off in shutdown
// - Unserviced watchdog interrupts first, then resets
// - Monitor window breach interrupts and wakes standby
// - Every pin interrupts and wakes, edge selectable
// - Reset pin wakes and resets from every mode
package pmcm_pkg;
    // Power modes, Gray coded along active-idle-standby-shutdown
    typedef enum logic [1:0] {
        PMCM_ACTIVE = 2'h0,
        PMCM_IDLE = 2'h1,
        PMCM_STANDBY = 2'h3,
        PMCM_SHUTDOWN = 2'h2
    } pmcm_mode_t;
    // Recorded reset causes
    typedef enum logic [1:0] {
        PMCM_CAUSE_POR = 2'h0,
        PMCM_CAUSE_PIN = 2'h1,
        PMCM_CAUSE_WAKE = 2'h2,
        PMCM_CAUSE_WDOG = 2'h3
    } pmcm_cause_t;
    // Slow clock sources
    typedef enum logic [1:0] {
        PMCM_LF_RC = 2'h0,
        PMCM_LF_XTAL = 2'h1,
        PMCM_LF_EXT = 2'h2
    } pmcm_lf_src_t;
    // Clock controls toward the clock tree
    typedef struct packed {
        logic main_en;
        logic main_xtal;
        logic medium_en;
        logic medium_rc;
        logic slow_en;
        pmcm_lf_src_t slow_src;
        logic slow_out_en;
        logic radio_ok;
    } pmcm_clk_t;
    // Power and gating controls toward the domains
    typedef struct packed {
        logic core_pwr;
        logic aon_pwr;
        logic sensor_pwr;
        logic cpu_clk;
        logic mem_clk;
        logic periph_clk;
        logic retain;
        logic io_hold;
    } pmcm_pwr_t;
    localparam int PMCM_CLK_KHZ = 100000;
    localparam int PMCM_WDOG_KHZ = 1500;
    localparam int PMCM_RADIO_KHZ = 4000;
    localparam int PMCM_WDOG_CYC = PMCM_CLK_KHZ / PMCM_WDOG_KHZ;
    localparam int PMCM_RADIO_CYC = PMCM_CLK_KHZ / PMCM_RADIO_KHZ;
    localparam logic [6:0] PMCM_WDOG_TICK = 7'(PMCM_WDOG_CYC - 1);
    localparam logic [6:0] PMCM_RADIO_TICK = 7'(PMCM_RADIO_CYC - 1);
    localparam logic [31:0] PMCM_WDOG_RST = 32'h0000_ffff;
endpackage

// ### logic/pmcm_top.sv
/*
 Power-mode sequencer, clock-enable manager, pin latch, wake and reset
 cause logic, radio timer and watchdog of the wireless controller.
 Assumes all inputs synchronous to clk_i; the processor posts mode
 requests as one-cycle strobes and the clock tree obeys the enables.
*/
`timescale 1ns/1ps
module pmcm_top #(
    parameter int NPIN = 31,
    parameter int MONW = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic req_valid_i,
    input wire pmcm_pkg::pmcm_mode_t req_mode_i,
    input wire logic irq_event_i,
    input wire logic ext_wake_i,
    input wire logic rtc_event_i,
    input wire logic sensor_event_i,
    input wire logic main_xtal_sel_i,
    input wire pmcm_pkg::pmcm_lf_src_t slow_src_i,
    input wire logic slow_out_req_i,
    input wire logic radio_en_i,
    input wire logic [31:0] rtc_net_time_i,
    input wire logic wdog_enable_i,
    input wire logic wdog_disable_i,
    input wire logic wdog_kick_i,
    input wire logic [31:0] wdog_load_i,
    input wire logic debug_halt_i,
    input wire logic [MONW-1:0] temp_i,
    input wire logic [MONW-1:0] temp_lo_i,
    input wire logic [MONW-1:0] temp_hi_i,
    input wire logic [MONW-1:0] vdd_i,
    input wire logic [MONW-1:0] vdd_lo_i,
    input wire logic [MONW-1:0] vdd_hi_i,
    input wire logic [NPIN-1:0] pin_in_i,
    input wire logic [NPIN-1:0] pin_rise_sel_i,
    input wire logic [NPIN-1:0] pin_wake_en_i,
    input wire logic [NPIN-1:0] pin_sd_wake_en_i,
    input wire logic [NPIN-1:0] core_pin_out_i,
    input wire logic [NPIN-1:0] core_pin_oe_i,
    output pmcm_pkg::pmcm_mode_t mode_o,
    output pmcm_pkg::pmcm_clk_t clk_ctrl_o,
    output pmcm_pkg::pmcm_pwr_t pwr_ctrl_o,
    output logic cpu_resume_o,
    output logic sys_reset_o,
    output pmcm_pkg::pmcm_cause_t reset_cause_o,
    output logic [NPIN-1:0] pin_out_o,
    output logic [NPIN-1:0] pin_oe_o,
    output logic [NPIN-1:0] pin_irq_o,
    output logic mon_irq_o,
    output logic [31:0] radio_time_o,
    output logic wdog_irq_o,
    output logic wdog_running_o
);
    pmcm_pkg::pmcm_mode_t mode_r, mode_nxt;
    pmcm_pkg::pmcm_cause_t cause_r;
    logic [NPIN-1:0] pin_prev_r, sd_snap_r, pin_out_r, pin_oe_r, pin_irq_r;
    logic mon_out_r, mon_irq_r, resume_r, sysrst_r, radio_en_r;
    logic [6:0] radio_div_r, wdog_div_r;
    logic [31:0] radio_time_r, wdog_cnt_r;
    logic wdog_en_r, wdog_irq_r;

    // Pin edge detection with per-pin polarity
    wire [NPIN-1:0] pin_rise = pin_in_i & ~pin_prev_r;
    wire [NPIN-1:0] pin_fall = ~pin_in_i & pin_prev_r;
    wire [NPIN-1:0] pin_edge = (pin_rise & pin_rise_sel_i) | (pin_fall & ~pin_rise_sel_i);
    wire pin_wake = |(pin_edge & pin_wake_en_i);

    // Window comparators: event on leaving the window
    wire mon_out = (temp_i < temp_lo_i) | (temp_i > temp_hi_i)
                 | (vdd_i < vdd_lo_i) | (vdd_i > vdd_hi_i);
    wire mon_evt = mon_out & ~mon_out_r;

    // Wake and reset sources
    wire stby_wake = ext_wake_i | rtc_event_i | sensor_event_i | mon_evt | pin_wake;
    wire sd_wake = (mode_r == pmcm_pkg::PMCM_SHUTDOWN)
                 & (|(pin_sd_wake_en_i & (pin_in_i ^ sd_snap_r)));
    wire pin_rst = ~reset_pin_n_i;
    wire wdog_tick = wdog_div_r == pmcm_pkg::PMCM_WDOG_TICK;
    wire wdog_zero = wdog_cnt_r == 32'h0;
    wire wdog_frozen = (mode_r == pmcm_pkg::PMCM_STANDBY) | debug_halt_i;
    wire wdog_step = wdog_en_r & ~wdog_frozen & wdog_tick;
    wire wdog_bite = wdog_step & wdog_zero & wdog_irq_r;
    wire wdog_bark = wdog_step & wdog_zero & ~wdog_irq_r;
    wire warm_rst = pin_rst | sd_wake | wdog_bite;
    wire in_low = (mode_r == pmcm_pkg::PMCM_STANDBY) | (mode_r == pmcm_pkg::PMCM_SHUTDOWN);
    wire idle_exit = irq_event_i | (|pin_edge) | mon_evt | wdog_bark | stby_wake;

    // Mode sequencing; only software leaves active
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pmcm_pkg::PMCM_ACTIVE: begin
                if (req_valid_i) begin
                    mode_nxt = req_mode_i;
                end
            end
            pmcm_pkg::PMCM_IDLE: begin
                if (idle_exit) begin
                    mode_nxt = pmcm_pkg::PMCM_ACTIVE;
                end
            end
            pmcm_pkg::PMCM_STANDBY: begin
                if (stby_wake) begin
                    mode_nxt = pmcm_pkg::PMCM_ACTIVE;
                end
            end
            pmcm_pkg::PMCM_SHUTDOWN: mode_nxt = pmcm_pkg::PMCM_SHUTDOWN;
            default: mode_nxt = pmcm_pkg::PMCM_ACTIVE;
        endcase
        if (warm_rst) begin
            mode_nxt = pmcm_pkg::PMCM_ACTIVE;
        end
    end

    // Mode, resume and reset state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r <= pmcm_pkg::PMCM_ACTIVE;
            resume_r <= 1'b0;
            sysrst_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            resume_r <= (mode_r == pmcm_pkg::PMCM_STANDBY) & stby_wake & ~warm_rst;
            sysrst_r <= warm_rst;
        end
    end

    // Reset cause, power-on unless a later reset names itself
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cause_r <= pmcm_pkg::PMCM_CAUSE_POR;
        end else if (pin_rst) begin
            cause_r <= pmcm_pkg::PMCM_CAUSE_PIN;
        end else if (sd_wake) begin
            cause_r <= pmcm_pkg::PMCM_CAUSE_WAKE;
        end else if (wdog_bite) begin
            cause_r <= pmcm_pkg::PMCM_CAUSE_WDOG;
        end
    end

    // Pin latch: follows the core while awake, frozen in standby and shutdown
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
            sd_snap_r <= '0;
        end else begin
            if (!in_low && !(mode_nxt == pmcm_pkg::PMCM_STANDBY)
                    && !(mode_nxt == pmcm_pkg::PMCM_SHUTDOWN)) begin
                pin_out_r <= core_pin_out_i;
                pin_oe_r <= core_pin_oe_i;
            end
            if (mode_r != pmcm_pkg::PMCM_SHUTDOWN) begin
                sd_snap_r <= pin_in_i;
            end
        end
    end

    // Pin and monitor interrupt pulses
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_prev_r <= '0;
            pin_irq_r <= '0;
            mon_out_r <= 1'b0;
            mon_irq_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_in_i;
            pin_irq_r <= pin_edge;
            mon_out_r <= mon_out;
            mon_irq_r <= mon_evt;
        end
    end

    // Radio timer at 4 MHz, reloaded from RTC time on radio switch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || warm_rst) begin
            radio_en_r <= 1'b0;
            radio_div_r <= '0;
            radio_time_r <= '0;
        end else begin
            radio_en_r <= radio_en_i;
            if (radio_en_i != radio_en_r) begin
                radio_time_r <= rtc_net_time_i;
                radio_div_r <= '0;
            end else if (radio_div_r == pmcm_pkg::PMCM_RADIO_TICK) begin
                radio_div_r <= '0;
                radio_time_r <= radio_time_r + 32'h1;
            end else begin
                radio_div_r <= radio_div_r + 7'h1;
            end
        end
    end

    // Watchdog: sticky enable, bark then bite, frozen in standby and debug
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || warm_rst || mode_r == pmcm_pkg::PMCM_SHUTDOWN) begin
            wdog_en_r <= 1'b0;
            wdog_irq_r <= 1'b0;
            wdog_div_r <= '0;
            wdog_cnt_r <= pmcm_pkg::PMCM_WDOG_RST;
        end else begin
            wdog_en_r <= wdog_en_r | wdog_enable_i;
            if (wdog_en_r && !wdog_frozen) begin
                wdog_div_r <= wdog_tick ? 7'h0 : wdog_div_r + 7'h1;
            end
            if (wdog_kick_i || (wdog_enable_i && !wdog_en_r)) begin
                wdog_cnt_r <= wdog_load_i;
                wdog_irq_r <= wdog_irq_r & ~wdog_kick_i;
            end else if (wdog_bark) begin
                wdog_irq_r <= 1'b1;
                wdog_cnt_r <= wdog_load_i;
            end else if (wdog_step) begin
                wdog_cnt_r <= wdog_cnt_r - 32'h1;
            end
        end
    end

    // Clock enables per mode
    wire awake = (mode_r == pmcm_pkg::PMCM_ACTIVE) | (mode_r == pmcm_pkg::PMCM_IDLE);
    assign clk_ctrl_o.main_en = awake;
    assign clk_ctrl_o.main_xtal = main_xtal_sel_i;
    assign clk_ctrl_o.medium_en = mode_r != pmcm_pkg::PMCM_SHUTDOWN;
    assign clk_ctrl_o.medium_rc = 1'b1;
    assign clk_ctrl_o.slow_en = mode_r != pmcm_pkg::PMCM_SHUTDOWN;
    assign clk_ctrl_o.slow_src = slow_src_i;
    assign clk_ctrl_o.slow_out_en = slow_out_req_i & clk_ctrl_o.slow_en
                                  & (slow_src_i != pmcm_pkg::PMCM_LF_EXT);
    assign clk_ctrl_o.radio_ok = awake & main_xtal_sel_i & radio_en_i;

    // Power and gating per mode
    assign pwr_ctrl_o.core_pwr = awake;
    assign pwr_ctrl_o.aon_pwr = mode_r != pmcm_pkg::PMCM_SHUTDOWN;
    assign pwr_ctrl_o.sensor_pwr = mode_r != pmcm_pkg::PMCM_SHUTDOWN;
    assign pwr_ctrl_o.cpu_clk = mode_r == pmcm_pkg::PMCM_ACTIVE;
    assign pwr_ctrl_o.mem_clk = mode_r == pmcm_pkg::PMCM_ACTIVE;
    assign pwr_ctrl_o.periph_clk = awake;
    assign pwr_ctrl_o.retain = mode_r == pmcm_pkg::PMCM_STANDBY;
    assign pwr_ctrl_o.io_hold = in_low;

    // Output drive
    assign mode_o = mode_r;
    assign cpu_resume_o = resume_r;
    assign sys_reset_o = sysrst_r;
    assign reset_cause_o = cause_r;
    assign pin_out_o = pin_out_r;
    assign pin_oe_o = pin_oe_r;
    assign pin_irq_o = pin_irq_r;
    assign mon_irq_o = mon_irq_r;
    assign radio_time_o = radio_time_r;
    assign wdog_irq_o = wdog_irq_r;
    assign wdog_running_o = wdog_en_r & ~wdog_frozen;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_idle_clk_gate: assert property (mode_o == pmcm_pkg::PMCM_IDLE |->
        !pwr_ctrl_o.cpu_clk && pwr_ctrl_o.periph_clk) else $error("idle gating wrong");
    a_idle_irq_exit: assert property (mode_o == pmcm_pkg::PMCM_IDLE && irq_event_i |=>
        mode_o == pmcm_pkg::PMCM_ACTIVE) else $error("idle not left on irq");
    a_stby_power_aon: assert property (mode_o == pmcm_pkg::PMCM_STANDBY |->
        pwr_ctrl_o.aon_pwr && !pwr_ctrl_o.core_pwr && !clk_ctrl_o.main_en)
        else $error("standby power wrong");
    a_stby_resume: assert property (mode_o == pmcm_pkg::PMCM_STANDBY && rtc_event_i
        && reset_pin_n_i |=> cpu_resume_o && !sys_reset_o) else $error("no resume");
    a_pin_hold: assert property (mode_o == pmcm_pkg::PMCM_STANDBY ##1
        mode_o == pmcm_pkg::PMCM_STANDBY |-> $stable(pin_out_o)) else $error("pins moved");
    a_sd_power_off: assert property (mode_o == pmcm_pkg::PMCM_SHUTDOWN |->
        !pwr_ctrl_o.aon_pwr && !clk_ctrl_o.slow_en && !wdog_running_o)
        else $error("shutdown power wrong");
    a_sd_wake_cause: assert property (sd_wake && reset_pin_n_i |=> sys_reset_o
        && reset_cause_o == pmcm_pkg::PMCM_CAUSE_WAKE) else $error("wake cause wrong");
    a_rst_pin_wake: assert property (!reset_pin_n_i |=> sys_reset_o
        && mode_o == pmcm_pkg::PMCM_ACTIVE && reset_cause_o == pmcm_pkg::PMCM_CAUSE_PIN)
        else $error("reset pin ignored");
    a_radio_xtal: assert property (clk_ctrl_o.radio_ok |-> clk_ctrl_o.main_xtal)
        else $error("radio on RC clock");
    a_wdog_sticky: assert property (wdog_en_r && wdog_disable_i && !warm_rst
        && mode_r != pmcm_pkg::PMCM_SHUTDOWN |=> wdog_en_r) else $error("watchdog stopped");
    a_wdog_freeze: assert property (wdog_en_r && debug_halt_i && !warm_rst && !wdog_kick_i
        |=> $stable(wdog_cnt_r)) else $error("watchdog ran frozen");
    a_wdog_bark_first: assert property (wdog_bite |-> $past(wdog_irq_r))
        else $error("bite before bark");
    a_stay_active: assert property (mode_o == pmcm_pkg::PMCM_ACTIVE && !req_valid_i |=>
        mode_o == pmcm_pkg::PMCM_ACTIVE) else $error("left active alone");

    c_idle_round: cover property (mode_o == pmcm_pkg::PMCM_IDLE ##1
        mode_o == pmcm_pkg::PMCM_ACTIVE);
    c_stby_wake: cover property (mode_o == pmcm_pkg::PMCM_STANDBY ##1 cpu_resume_o);
    c_sd_wake: cover property (sd_wake ##1 sys_reset_o);
    c_wdog_bite: cover property (wdog_bite);
endmodule

// ### sim/tb_top.sv
/*
 Self-checking bench for the power-mode and clock manager.
 Assumes pmcm_pkg is compiled first; drives every input at or a few ns after the falling edge.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int NPIN = 31;
    localparam int MONW = 12;
    logic clk_i, rst_n_i, reset_pin_n_i, req_valid_i, irq_event_i;
    logic ext_wake_i, rtc_event_i, sensor_event_i, main_xtal_sel_i, slow_out_req_i, radio_en_i;
    logic wdog_enable_i, wdog_disable_i, wdog_kick_i, debug_halt_i, cpu_resume_o, sys_reset_o;
    logic mon_irq_o, wdog_irq_o, wdog_running_o, seen;
    pmcm_pkg::pmcm_mode_t req_mode_i, mode_o;
    pmcm_pkg::pmcm_lf_src_t slow_src_i;
    pmcm_pkg::pmcm_clk_t clk_ctrl_o;
    pmcm_pkg::pmcm_pwr_t pwr_ctrl_o;
    pmcm_pkg::pmcm_cause_t reset_cause_o;
    logic [31:0] rtc_net_time_i, wdog_load_i, radio_time_o;
    logic [MONW-1:0] temp_i, temp_lo_i, temp_hi_i, vdd_i, vdd_lo_i, vdd_hi_i;
    logic [NPIN-1:0] pin_in_i, pin_rise_sel_i, pin_wake_en_i, pin_sd_wake_en_i;
    logic [NPIN-1:0] core_pin_out_i, core_pin_oe_i, pin_out_o, pin_oe_o, pin_irq_o;
    int n_errors = 0;
    int cmp_count = 0;

    pmcm_top #(.NPIN(NPIN), .MONW(MONW)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
        .req_valid_i(req_valid_i), .req_mode_i(req_mode_i), .irq_event_i(irq_event_i),
        .ext_wake_i(ext_wake_i), .rtc_event_i(rtc_event_i), .sensor_event_i(sensor_event_i),
        .main_xtal_sel_i(main_xtal_sel_i), .slow_src_i(slow_src_i),
        .slow_out_req_i(slow_out_req_i), .radio_en_i(radio_en_i),
        .rtc_net_time_i(rtc_net_time_i), .wdog_enable_i(wdog_enable_i),
        .wdog_disable_i(wdog_disable_i), .wdog_kick_i(wdog_kick_i), .wdog_load_i(wdog_load_i),
        .debug_halt_i(debug_halt_i), .temp_i(temp_i), .temp_lo_i(temp_lo_i),
        .temp_hi_i(temp_hi_i), .vdd_i(vdd_i), .vdd_lo_i(vdd_lo_i), .vdd_hi_i(vdd_hi_i),
        .pin_in_i(pin_in_i), .pin_rise_sel_i(pin_rise_sel_i), .pin_wake_en_i(pin_wake_en_i),
        .pin_sd_wake_en_i(pin_sd_wake_en_i), .core_pin_out_i(core_pin_out_i),
        .core_pin_oe_i(core_pin_oe_i), .mode_o(mode_o), .clk_ctrl_o(clk_ctrl_o),
        .pwr_ctrl_o(pwr_ctrl_o), .cpu_resume_o(cpu_resume_o), .sys_reset_o(sys_reset_o),
        .reset_cause_o(reset_cause_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pin_irq_o(pin_irq_o), .mon_irq_o(mon_irq_o), .radio_time_o(radio_time_o),
        .wdog_irq_o(wdog_irq_o), .wdog_running_o(wdog_running_o)
    );

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Post one mode request strobe, return at the falling edge after it is taken
    task automatic req(input pmcm_pkg::pmcm_mode_t m);
        req_valid_i = 1'b1;
        req_mode_i = m;
        @(negedge clk_i);
        req_valid_i = 1'b0;
    endtask

    // Print counts and the verdict, then stop
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        conclude();
    end

    // Main sequence
    initial begin
        {rst_n_i, reset_pin_n_i, req_valid_i, irq_event_i, ext_wake_i} = 5'h08;
        {rtc_event_i, sensor_event_i, slow_out_req_i, radio_en_i, debug_halt_i} = 5'h00;
        {wdog_enable_i, wdog_disable_i, wdog_kick_i, main_xtal_sel_i} = 4'h1;
        req_mode_i = pmcm_pkg::PMCM_ACTIVE;
        slow_src_i = pmcm_pkg::PMCM_LF_XTAL;
        rtc_net_time_i = 32'h1234_0000;
        wdog_load_i = 32'h0000_0003;
        {temp_i, temp_lo_i, temp_hi_i} = {12'h096, 12'h064, 12'h0c8};
        {vdd_i, vdd_lo_i, vdd_hi_i} = {12'h096, 12'h064, 12'h0c8};
        {pin_in_i, pin_rise_sel_i, pin_wake_en_i, pin_sd_wake_en_i} = '0;
        core_pin_out_i = 31'h0000_0005;
        core_pin_oe_i = '1;
        repeat (2) @(negedge clk_i);
        check(sys_reset_o, 1'b1);
        check(reset_cause_o, pmcm_pkg::PMCM_CAUSE_POR);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(sys_reset_o, 1'b0);
        check(pin_out_o, 32'h5);
        check(pin_oe_o, 32'h7fff_ffff);
        // Clock sources, slow clock out and radio gating
        check(clk_ctrl_o.medium_rc, 1'b1);
        check({clk_ctrl_o.main_en, clk_ctrl_o.slow_en}, 2'h3);
        check(clk_ctrl_o.slow_src, pmcm_pkg::PMCM_LF_XTAL);
        slow_out_req_i = 1'b1;
        #1 check(clk_ctrl_o.slow_out_en, 1'b1);
        slow_src_i = pmcm_pkg::PMCM_LF_EXT;
        #1 check(clk_ctrl_o.slow_out_en, 1'b0);
        slow_src_i = pmcm_pkg::PMCM_LF_RC;
        radio_en_i = 1'b1;
        #1 check(clk_ctrl_o.radio_ok, 1'b1);
        main_xtal_sel_i = 1'b0;
        #1 check(clk_ctrl_o.radio_ok, 1'b0);
        main_xtal_sel_i = 1'b1;
        @(negedge clk_i);
        check(radio_time_o, 32'h1234_0000);
        repeat (30) @(negedge clk_i);
        check(radio_time_o, 32'h1234_0001);
        // Pin edge interrupt on a rising edge
        pin_rise_sel_i = 31'h0000_0002;
        pin_in_i = 31'h0000_0002;
        seen = 1'b0;
        repeat (3) @(negedge clk_i) seen |= pin_irq_o[1];
        check(seen, 1'b1);
        check(pin_irq_o, 32'h0);
        // Monitor window breach
        temp_i = 12'h0fa;
        seen = 1'b0;
        repeat (3) @(negedge clk_i) seen |= mon_irq_o;
        check(seen, 1'b1);
        temp_i = 12'h096;
        @(negedge clk_i);
        // Idle gates processor and memory only, any interrupt returns
        req(pmcm_pkg::PMCM_IDLE);
        check(mode_o, pmcm_pkg::PMCM_IDLE);
        check({pwr_ctrl_o.cpu_clk, pwr_ctrl_o.mem_clk, pwr_ctrl_o.periph_clk}, 3'h1);
        check(clk_ctrl_o.main_en, 1'b1);
        irq_event_i = 1'b1;
        @(negedge clk_i);
        irq_event_i = 1'b0;
        check(mode_o, pmcm_pkg::PMCM_ACTIVE);
        // Standby with each of the ext, rtc and sensor wake sources
        for (int k = 0; k < 3; k++) begin
            req(pmcm_pkg::PMCM_STANDBY);
            core_pin_out_i = 31'h0000_000a;
            check({pwr_ctrl_o.core_pwr, pwr_ctrl_o.aon_pwr, pwr_ctrl_o.retain}, 3'h3);
            check({clk_ctrl_o.main_en, clk_ctrl_o.slow_en}, 2'h1);
            req(pmcm_pkg::PMCM_IDLE);
            repeat (2) @(negedge clk_i);
            check(mode_o, pmcm_pkg::PMCM_STANDBY);
            check({pwr_ctrl_o.io_hold, pin_out_o}, {1'b1, 31'h5});
            {sensor_event_i, rtc_event_i, ext_wake_i} = 3'h1 << k;
            @(negedge clk_i);
            {sensor_event_i, rtc_event_i, ext_wake_i} = 3'h0;
            check(mode_o, pmcm_pkg::PMCM_ACTIVE);
            check({cpu_resume_o, sys_reset_o}, 2'h2);
            core_pin_out_i = 31'h0000_0005;
            repeat (2) @(negedge clk_i);
        end
        // Reset pin from standby, held off while low
        req(pmcm_pkg::PMCM_STANDBY);
        reset_pin_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(mode_o, pmcm_pkg::PMCM_ACTIVE);
        check({sys_reset_o, reset_cause_o}, {1'b1, pmcm_pkg::PMCM_CAUSE_PIN});
        check(radio_time_o, 32'h0);
        reset_pin_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        // Shutdown: everything off, pins latched, the rtc event stays, the wake pin leaves
        pin_sd_wake_en_i = 31'h0000_0001;
        core_pin_out_i = 31'h0000_0005;
        repeat (2) @(negedge clk_i);
        req(pmcm_pkg::PMCM_SHUTDOWN);
        core_pin_out_i = '0;
        check({pwr_ctrl_o.aon_pwr, pwr_ctrl_o.sensor_pwr, pwr_ctrl_o.core_pwr}, 3'h0);
        check({clk_ctrl_o.main_en, clk_ctrl_o.medium_en, clk_ctrl_o.slow_en}, 3'h0);
        rtc_event_i = 1'b1;
        @(negedge clk_i);
        rtc_event_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(mode_o, pmcm_pkg::PMCM_SHUTDOWN);
        check(pin_out_o, 32'h5);
        pin_in_i = 31'h0000_0001;
        seen = 1'b0;
        repeat (3) @(negedge clk_i) seen |= sys_reset_o;
        check(seen, 1'b1);
        check(mode_o, pmcm_pkg::PMCM_ACTIVE);
        check(reset_cause_o, pmcm_pkg::PMCM_CAUSE_WAKE);
        // Watchdog: cannot be stopped, freezes, barks then bites
        wdog_enable_i = 1'b1;
        @(negedge clk_i);
        {wdog_enable_i, wdog_disable_i} = 2'h1;
        @(negedge clk_i);
        wdog_disable_i = 1'b0;
        check(wdog_running_o, 1'b1);
        debug_halt_i = 1'b1;
        #1 check(wdog_running_o, 1'b0);
        debug_halt_i = 1'b0;
        req(pmcm_pkg::PMCM_STANDBY);
        check(wdog_running_o, 1'b0);
        ext_wake_i = 1'b1;
        @(negedge clk_i);
        ext_wake_i = 1'b0;
        check(wdog_running_o, 1'b1);
        for (int n = 0; n < 1000 && wdog_irq_o !== 1'b1; n++) @(negedge clk_i);
        check({wdog_irq_o, sys_reset_o}, 2'h2);
        wdog_kick_i = 1'b1;
        @(negedge clk_i);
        wdog_kick_i = 1'b0;
        @(negedge clk_i);
        check(wdog_irq_o, 1'b0);
        seen = 1'b0;
        for (int n = 0; n < 2000 && sys_reset_o !== 1'b1; n++) begin
            @(negedge clk_i);
            seen |= wdog_irq_o;
        end
        check({seen, sys_reset_o}, 2'h3);
        check(reset_cause_o, pmcm_pkg::PMCM_CAUSE_WDOG);
        repeat (2) @(negedge clk_i);
        conclude();
    end
endmodule
